// ### design/mua_channel_one.sv
// Behaviour
// - Launch bit one queues one bus access.
// - Writing launch zero starts no access; fields still load.
// - Launch writes ignored unless machine enabled.
// - Launch bit self-clears after access completes.
// - All access writes blocked while launching.
// - Direction one writes, zero reads.
// - Read acknowledge bit reflects PHY answer.
// - Register index selects one of 32.
// - PHY index selects one of 32.
// - Data field sent or returned value.
// - Link source select fixed at zero.
// - Interrupt enable gates link change events.
// - Watched index picks monitored PHY link.
`timescale 1ns/1ns
module mua_channel_one #(
  parameter int PHY_COUNT = 32
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [mua_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [mua_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [mua_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [PHY_COUNT-1:0]       link_status,
  input  wire logic                       mgmt_clk_in,
  input  wire logic                       mdio_in,
  output logic                            mdio_out,
  output logic                            mdio_oe,
  output logic                            irq
);
  import mua_pkg::*;

  mua_state_type s_reg;
  mua_state_type s_next;

  logic       mdc_rise;
  logic       mdc_fall;
  logic       mdi;
  logic       wr_acc;
  logic       done;
  logic       cur_link;
  logic [1:0] ev;

  assign mdc_rise = s_reg.mdc_s[1] & ~s_reg.mdc_s[2];
  assign mdc_fall = ~s_reg.mdc_s[1] & s_reg.mdc_s[2];
  assign mdi      = s_reg.mdi_s[1];
  assign wr_acc   = reg_wr && reg_addr == ACCESS_OFS;
  assign done     = s_reg.phase == MUA_SAMPLE && mdc_rise
                    && s_reg.bitn == BIT_LAST;
  assign cur_link = link_status[s_reg.wphy];

  assign reg_rdata = s_reg.rdata;
  assign mdio_out  = s_reg.mdo;
  assign mdio_oe   = s_reg.oe;
  assign irq       = s_reg.irq;

  always_comb begin
    s_next = s_reg;
    ev     = 2'h0;
    s_next.mdc_s = {s_reg.mdc_s[1:0], mgmt_clk_in};
    s_next.mdi_s = {s_reg.mdi_s[0], mdio_in};

    if (wr_acc && !s_reg.go) begin
      s_next.dir  = reg_wdata[DIR_BIT];
      s_next.ack  = reg_wdata[ACK_BIT];
      s_next.rgi  = reg_wdata[REG_LSB +: 5];
      s_next.phi  = reg_wdata[PHY_LSB +: 5];
      s_next.data = reg_wdata[15:0];
      if (reg_wdata[GO_BIT] && s_reg.en) begin
        s_next.go = 1'b1;
      end
    end
    if (reg_wr && reg_addr == SELECT_OFS) begin
      s_next.irq_on = reg_wdata[IRQ_ON_BIT];
      s_next.wphy   = reg_wdata[WPHY_LSB +: 5];
    end
    if (reg_wr && reg_addr == CTRL_OFS) begin
      s_next.en = reg_wdata[ENABLE_BIT];
    end
    if (reg_wr && reg_addr == MASK_OFS) begin
      s_next.msk = reg_wdata[1:0];
    end

    case (s_reg.phase)
      MUA_IDLE: begin
        s_next.oe = 1'b0;
        if (s_reg.go && s_reg.en) begin
          s_next.frame = {PREAMBLE, START,
                          s_reg.dir ? OP_WR : OP_RD,
                          s_reg.phi, s_reg.rgi,
                          s_reg.dir ? TA_WR : TA_RD,
                          s_reg.dir ? s_reg.data : 16'hFFFF};
          s_next.bitn  = 6'h00;
          s_next.phase = MUA_DRIVE;
        end
      end
      MUA_DRIVE: begin
        if (mdc_fall) begin
          s_next.mdo = s_reg.frame[63];
          s_next.oe  = s_reg.dir || s_reg.bitn < TA_FIRST;
          s_next.phase = MUA_SAMPLE;
        end
      end
      MUA_SAMPLE: begin
        if (mdc_rise) begin
          s_next.frame = {s_reg.frame[62:0], mdi};
          s_next.bitn  = s_reg.bitn + 6'h01;
          s_next.phase = MUA_DRIVE;
          // PHY pulls line low to acknowledge
          if (s_reg.bitn == TA_ACK) begin
            s_next.rd_ack = ~mdi;
          end
          if (done) begin
            if (!s_reg.dir) begin
              s_next.ack  = s_reg.rd_ack;
              s_next.data = {s_reg.frame[14:0], mdi};
            end
            s_next.go    = 1'b0;
            s_next.oe    = 1'b0;
            s_next.phase = MUA_IDLE;
            ev[ST_DONE]  = 1'b1;
          end
        end
      end
      default: begin
        s_next.phase = MUA_IDLE;
      end
    endcase

    s_next.link_prev = cur_link;
    s_next.wphy_prev = s_reg.wphy;
    if (s_reg.irq_on && s_reg.wphy == s_reg.wphy_prev
        && cur_link != s_reg.link_prev) begin
      ev[ST_LINK] = 1'b1;
    end

    // Hardware events win over a same-cycle clear.
    if (reg_wr && reg_addr == STAT_OFS) begin
      s_next.sts = s_reg.sts & ~reg_wdata[1:0];
    end
    s_next.sts = s_next.sts | ev;
    s_next.irq = |(s_next.sts & s_next.msk);

    s_next.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        ACCESS_OFS: s_next.rdata = {s_reg.go, s_reg.dir, s_reg.ack,
                                    3'h0, s_reg.rgi, s_reg.phi,
                                    s_reg.data};
        SELECT_OFS: s_next.rdata = {24'h000000, 1'b0, s_reg.irq_on,
                                    1'b0, s_reg.wphy};
        CTRL_OFS:   s_next.rdata = {31'h00000000, s_reg.en};
        STAT_OFS:   s_next.rdata = {30'h00000000, s_reg.sts};
        MASK_OFS:   s_next.rdata = {30'h00000000, s_reg.msk};
        default:    s_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  sequence s_launch_wr(logic v);
    wr_acc && !s_reg.go && s_reg.en && reg_wdata[GO_BIT] == v;
  endsequence

  property p_go_set;
    @(posedge clock) disable iff (rst)
      s_launch_wr(1'b1) |=> s_reg.go;
  endproperty
  a_go_set: assert property (p_go_set)
    else $error("launch bit not set by write");

  property p_go_zero;
    @(posedge clock) disable iff (rst)
      s_launch_wr(1'b0) |=> !s_reg.go ##1 s_reg.phase == MUA_IDLE;
  endproperty
  a_go_zero: assert property (p_go_zero)
    else $error("zero launch write started access");

  property p_go_disabled;
    @(posedge clock) disable iff (rst)
      wr_acc && !s_reg.go && !s_reg.en |=> !s_reg.go;
  endproperty
  a_go_disabled: assert property (p_go_disabled)
    else $error("launch accepted while disabled");

  property p_go_clear;
    @(posedge clock) disable iff (rst)
      done |=> !s_reg.go && s_reg.phase == MUA_IDLE && s_reg.sts[ST_DONE];
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("launch bit not cleared at completion");

  property p_block;
    @(posedge clock) disable iff (rst)
      wr_acc && s_reg.go && !done |=>
        $stable({s_reg.dir, s_reg.ack, s_reg.rgi, s_reg.phi, s_reg.data});
  endproperty
  a_block: assert property (p_block)
    else $error("access fields changed while launched");

  property p_turnaround;
    @(posedge clock) disable iff (rst)
      s_reg.phase == MUA_DRIVE && mdc_fall && s_reg.bitn == TA_FIRST
        |=> s_reg.oe == s_reg.dir;
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("turnaround drive wrong for direction");

  property p_ack;
    @(posedge clock) disable iff (rst)
      done && !s_reg.dir |=> s_reg.ack == $past(s_reg.rd_ack);
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge bit mismatch after read");

  property p_link_off;
    @(posedge clock) disable iff (rst)
      !s_reg.irq_on && !s_reg.sts[ST_LINK] && !wr_acc
        |=> !s_reg.sts[ST_LINK];
  endproperty
  a_link_off: assert property (p_link_off)
    else $error("link event raised while disabled");

  sequence s_frame_start;
    s_reg.phase == MUA_IDLE && s_reg.go && s_reg.en;
  endsequence

  property p_frame_reg;
    @(posedge clock) disable iff (rst)
      s_frame_start |=> s_reg.frame[22:18] == $past(s_reg.rgi);
  endproperty
  a_frame_reg: assert property (p_frame_reg)
    else $error("frame register index wrong");

  property p_frame_phy;
    @(posedge clock) disable iff (rst)
      s_frame_start |=> s_reg.frame[27:23] == $past(s_reg.phi);
  endproperty
  a_frame_phy: assert property (p_frame_phy)
    else $error("frame PHY index wrong");

  property p_frame_data;
    @(posedge clock) disable iff (rst)
      s_frame_start ##0 s_reg.dir
        |=> s_reg.frame[15:0] == $past(s_reg.data);
  endproperty
  a_frame_data: assert property (p_frame_data)
    else $error("frame write data wrong");

  property p_lsrc_zero;
    @(posedge clock) disable iff (rst)
      reg_rd && reg_addr == SELECT_OFS |=> !s_reg.rdata[LSRC_BIT];
  endproperty
  a_lsrc_zero: assert property (p_lsrc_zero)
    else $error("link source select read as one");

  property p_link_on;
    @(posedge clock) disable iff (rst)
      s_reg.irq_on && s_reg.wphy == s_reg.wphy_prev
        && cur_link != s_reg.link_prev |=> s_reg.sts[ST_LINK];
  endproperty
  a_link_on: assert property (p_link_on)
    else $error("link change not recorded while enabled");

  property p_watch_move;
    @(posedge clock) disable iff (rst)
      s_reg.wphy != s_reg.wphy_prev && !s_reg.sts[ST_LINK]
        |=> !s_reg.sts[ST_LINK];
  endproperty
  a_watch_move: assert property (p_watch_move)
    else $error("link event raised by watched index change");

  property p_irq;
    @(posedge clock) disable iff (rst)
      ##1 s_reg.irq == |(s_reg.sts & s_reg.msk);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with status");
endmodule : mua_channel_one

// ### design/mua_pkg.sv
package mua_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] ACCESS_OFS = 8'h00;
  localparam logic [7:0] SELECT_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0C;
  localparam logic [7:0] MASK_OFS   = 8'h10;

  localparam int GO_BIT     = 31;
  localparam int DIR_BIT    = 30;
  localparam int ACK_BIT    = 29;
  localparam int REG_LSB    = 21;
  localparam int PHY_LSB    = 16;
  localparam int LSRC_BIT   = 7;
  localparam int IRQ_ON_BIT = 6;
  localparam int WPHY_LSB   = 0;
  localparam int ENABLE_BIT = 0;
  localparam int ST_DONE    = 0;
  localparam int ST_LINK    = 1;

  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [4:0]  IDX_RST  = 5'h00;
  localparam logic [1:0]  FLAG_RST = 2'h0;

  localparam logic [5:0]  BIT_LAST = 6'h3F;
  localparam logic [5:0]  TA_FIRST = 6'h2E;
  localparam logic [5:0]  TA_ACK   = 6'h2F;
  localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0]  START    = 2'h1;
  localparam logic [1:0]  OP_RD    = 2'h2;
  localparam logic [1:0]  OP_WR    = 2'h1;
  localparam logic [1:0]  TA_WR    = 2'h2;
  localparam logic [1:0]  TA_RD    = 2'h3;

  typedef enum logic [1:0] {
    MUA_IDLE,
    MUA_DRIVE,
    MUA_SAMPLE
  } mua_phase_type;

  typedef struct packed {
    mua_phase_type phase;
    logic          go;
    logic          dir;
    logic          ack;
    logic [4:0]    rgi;
    logic [4:0]    phi;
    logic [15:0]   data;
    logic          en;
    logic          irq_on;
    logic [4:0]    wphy;
    logic [4:0]    wphy_prev;
    logic          link_prev;
    logic [1:0]    sts;
    logic [1:0]    msk;
    logic [2:0]    mdc_s;
    logic [1:0]    mdi_s;
    logic [5:0]    bitn;
    logic [63:0]   frame;
    logic          rd_ack;
    logic          mdo;
    logic          oe;
    logic [31:0]   rdata;
    logic          irq;
  } mua_state_type;
endpackage : mua_pkg

// ### sim/mua_phy_model.sv
`timescale 1ns/1ns
module mua_phy_model #(
  parameter logic [4:0] MY_PHY = 5'h03
) (
  input  wire logic mdc,
  input  wire logic line,
  output logic      drv,
  output logic      drv_oe,
  output int        frames,
  output logic [11:0] hdr,
  output logic [15:0] wdata
);
  logic [15:0] mem [32];
  logic [31:0] sr;
  logic [15:0] sh;
  int          cnt;
  initial begin
    drv = 1'b1;
    drv_oe = 1'b0;
    frames = 0;
    cnt = 0;
    sr = 32'h00000000;
    hdr = 12'h000;
    for (int i = 0; i < 32; i++) mem[i] = 16'hC35A ^ 16'(i);
  end
  // Frames are found by their preamble and start pattern, not by timing.
  always @(posedge mdc) begin
    sr = {sr[30:0], line};
    if (cnt > 0) cnt++;
    else if (sr == 32'hFFFFFFFD) cnt = 1;
    if (cnt == 13) begin
      hdr = sr[11:0];
      sh = mem[sr[4:0]];
    end
    if (cnt == 31) begin
      if (hdr[11:5] == {2'h1, MY_PHY}) mem[hdr[4:0]] = sr[15:0];
      wdata = sr[15:0];
      frames++;
      cnt = 0;
    end
  end
  // Only the addressed device answers a read; otherwise the pull-up wins.
  always @(negedge mdc) begin
    drv_oe = hdr[11:5] == {2'h2, MY_PHY} && cnt >= 14 && cnt <= 30;
    drv = cnt >= 15 ? sh[15] : 1'b0;
    if (cnt >= 15) sh = sh << 1;
  end
endmodule : mua_phy_model

// ### sim/tb.sv
`timescale 1ns/1ns
module tb;
  import mua_pkg::*;
  localparam logic [4:0] PHY_A = 5'h03;
  logic        clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        mdc = 1'b0, run = 1'b0;
  logic        mdio_out, mdio_oe, irq, drv, drv_oe;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000, link_status = 32'h00000000;
  logic [31:0] reg_rdata, rv;
  logic [11:0] hdr;
  logic [15:0] wdata, d;
  logic [15:0] emem [32];
  logic [4:0]  r;
  int          mismatches = 0, num_checks = 0, frames, exp_frames = 0;
  int          seed = 97;
  wire         line = mdio_oe ? mdio_out : drv_oe ? drv : 1'b1;
  always #25 clock = ~clock;
  initial begin
    #7;
    forever #200 if (run) mdc = ~mdc;
  end
  mua_channel_one u_mua_channel_one (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_status(link_status), .mgmt_clk_in(mdc), .mdio_in(line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq(irq)
  );
  mua_phy_model #(.MY_PHY(PHY_A)) u_mua_phy_model (
    .mdc(mdc), .line(line), .drv(drv), .drv_oe(drv_oe), .frames(frames),
    .hdr(hdr), .wdata(wdata)
  );
  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(logic [31:0] seen, logic [31:0] exp, string name);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp, string name);
    rd(a);
    chk(rv, exp, name);
  endtask : rd_chk
  task automatic access(logic w, logic [4:0] p, logic [15:0] din);
    logic [31:0] req;
    req = {1'b1, w, 4'h0, r, p, din};
    wr(ACCESS_OFS, req);
    wr(ACCESS_OFS, 32'h00000000);
    rd_chk(ACCESS_OFS, req, "blocked");
    run = 1'b1;
    for (int i = 0; i < 800 && rv[GO_BIT] !== 1'b0; i++) rd(ACCESS_OFS);
    run = 1'b0;
    exp_frames++;
    chk(rv, {1'b0, w, !w && p == PHY_A, 3'h0, r, p,
        w ? din : p == PHY_A ? emem[r] : 16'hFFFF}, "access");
    chk(hdr, {w ? 2'h1 : 2'h2, p, r}, "frame");
    chk(frames, exp_frames, "frames");
    if (w) chk(wdata, din, "wdata");
    if (w && p == PHY_A) emem[r] = din;
    rd_chk(STAT_OFS, 32'h00000001, "done");
    wr(STAT_OFS, 32'h00000001);
  endtask : access
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 32; i++) emem[i] = 16'hC35A ^ 16'(i);
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd_chk(SELECT_OFS, 32'h00000000, "sel_rst");
    rd_chk(8'h14, 32'h00000000, "unmapped");
    wr(SELECT_OFS, 32'hFFFFFFFF);
    rd_chk(SELECT_OFS, 32'h0000005F, "sel_ro");
    wr(ACCESS_OFS, 32'hC0431234);
    rd_chk(ACCESS_OFS, 32'h40431234, "go_off");
    wr(CTRL_OFS, 32'h00000001);
    r = 5'($random(seed));
    d = 16'($random(seed));
    access(1'b1, PHY_A, d);
    access(1'b0, PHY_A, 16'h0000);
    r = 5'($random(seed));
    access(1'b0, PHY_A + 5'h01, 16'h0000);
    wr(ACCESS_OFS, 32'h00000000);
    run = 1'b1;
    repeat (100) @(posedge clock);
    run = 1'b0;
    chk(frames, exp_frames, "go_zero");
    wr(SELECT_OFS, 32'h00000045);
    wr(MASK_OFS, 32'h00000002);
    link_status <= 32'h00000060;
    repeat (4) @(posedge clock);
    chk(irq, 1'b1, "irq_on");
    rd_chk(STAT_OFS, 32'h00000002, "link");
    wr(STAT_OFS, 32'h00000002);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0, "irq_clr");
    wr(SELECT_OFS, 32'h00000005);
    link_status <= 32'h00000000;
    repeat (4) @(posedge clock);
    rd_chk(STAT_OFS, 32'h00000000, "irq_off");
    finish_test();
  end
endmodule : tb
